// ==== rtl/mcbr_pkg.sv ====
// constants, field layouts and register map of the microcore branch decider
// assumes a 16-bit instruction word and a 10-bit code RAM address
package mcbr_pkg;

	localparam int PC_W    = 10;
	localparam int INSTR_W = 16;
	localparam int CTL_W   = 16;
	localparam int FB_W    = 16;
	localparam int OFS_W   = 5;
	localparam int SEL_W   = 4;
	localparam int HS_N    = 5;
	localparam int LS_N    = 6;
	localparam int CTL_N   = 4;

	// instruction fields
	localparam int OPC_HI  = 15;
	localparam int OPC_LO  = 10;
	localparam int SEL_HI  = 9;
	localparam int SEL_LO  = 6;
	localparam int POL_BIT = 5;
	localparam int TGT_BIT = 4;
	localparam int OFS_HI  = 4;
	localparam int OFS_LO  = 0;
	localparam int TAIL_HI = 3;
	localparam int TAIL_LO = 0;

	// opcodes in bits 15..10, tail in bits 3..0
	localparam logic [5:0] OPC_CTL_REL = 6'h04;
	localparam logic [5:0] OPC_FB_ABS  = 6'h0e;
	localparam logic [5:0] OPC_FB_REL  = 6'h05;
	localparam logic [3:0] TAIL_FB_ABS = 4'h4;

	// feedback vector layout
	localparam int FB_LS_BASE = 10;

	// register indices; byte address is four times the index
	localparam logic [8:0] IDX_CTL_A0  = 9'h101;
	localparam logic [8:0] IDX_CTL_B0  = 9'h102;
	localparam logic [8:0] IDX_CTL_A1  = 9'h121;
	localparam logic [8:0] IDX_CTL_B1  = 9'h122;
	localparam logic [8:0] IDX_WSEL    = 9'h130;
	localparam logic [8:0] IDX_STATUS  = 9'h131;
	localparam logic [8:0] IDX_TAKEN   = 9'h132;
	localparam int         ADR_W       = 11;
	localparam int         IDX_LO      = 2;

	localparam logic [CTL_W-1:0] CTL_RESET   = 16'h0000;
	localparam logic [1:0]       WSEL_RESET  = 2'h0;
	localparam logic [15:0]      CNT_RESET   = 16'h0000;
	localparam logic [31:0]      RD_ZERO     = 32'h0000_0000;
	localparam logic [PC_W-1:0]  PC_STEP     = 10'h001;
	localparam logic [15:0]      CNT_STEP    = 16'h0001;

	typedef enum logic [1:0] {
		MCBR_CTL_REL,
		MCBR_FB_ABS,
		MCBR_FB_REL,
		MCBR_NONE
	} mcbr_kind_type;

endpackage

// ==== rtl/mcbr_bit_match.sv ====
// selects one bit of a 16-bit vector and compares it with a polarity
// assumes purely combinational use inside the branch decider
`timescale 1ns/100ps
module mcbr_bit_match (
	input  wire logic [mcbr_pkg::FB_W-1:0]  vec,
	input  wire logic [mcbr_pkg::SEL_W-1:0] index,
	input  wire logic                       pol,
	output logic                            match
);
	logic picked;

	always_comb begin
		picked = vec[index];
		match = (picked == pol);
	end
endmodule

// ==== rtl/mcbr_branch.sv ====
// microcore conditional branch decider with its wishbone register slave
// assumes instr_word and cur_pc are stable while instr_valid is high
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
module mcbr_branch (
	input  wire logic                       core_clk,
	input  wire logic                       resetn,
	// wishbone classic slave
	input  wire logic                       cyc_i,
	input  wire logic                       stb_i,
	input  wire logic                       we_i,
	input  wire logic [mcbr_pkg::ADR_W-1:0] adr_i,
	input  wire logic [3:0]                 sel_i,
	input  wire logic [31:0]                dat_i,
	output logic      [31:0]                dat_o,
	output logic                            ack_o,
	// instruction port
	input  wire logic                       instr_valid,
	input  wire logic [mcbr_pkg::INSTR_W-1:0] instr_word,
	input  wire logic [mcbr_pkg::PC_W-1:0]  cur_pc,
	input  wire logic [mcbr_pkg::PC_W-1:0]  jump_target_set0,
	input  wire logic [mcbr_pkg::PC_W-1:0]  jump_target_set1,
	// pre-driver feedback
	input  wire logic [mcbr_pkg::HS_N-1:0]  high_drv_drain_fb,
	input  wire logic [mcbr_pkg::HS_N-1:0]  high_drv_source_fb,
	input  wire logic [mcbr_pkg::LS_N-1:0]  low_drv_drain_fb,
	// decision
	output logic [mcbr_pkg::PC_W-1:0]       micro_program_counter,
	output logic                            pc_valid,
	output logic                            jump_taken,
	output logic                            branch_decoded
);
	typedef struct packed {
		logic [mcbr_pkg::CTL_N-1:0][mcbr_pkg::CTL_W-1:0] ctl;
		logic [1:0]                 wsel;
		logic                       ack;
		logic [31:0]                rdata;
		logic [mcbr_pkg::PC_W-1:0]  pc;
		logic                       valid;
		logic                       taken;
		logic                       decoded;
		logic [15:0]                taken_cnt;
	} mcbr_state_type;

	mcbr_state_type state_q;
	mcbr_state_type state_d;

	logic [mcbr_pkg::FB_W-1:0]  fb_vec;
	logic [mcbr_pkg::CTL_W-1:0] ctl_word;
	logic [mcbr_pkg::FB_W-1:0]  test_vec;
	logic                       cond_match;
	mcbr_pkg::mcbr_kind_type    kind;
	logic [5:0]                 opcode;
	logic [mcbr_pkg::PC_W-1:0]  rel_target;
	logic [mcbr_pkg::PC_W-1:0]  abs_target;
	logic [mcbr_pkg::PC_W-1:0]  seq_target;
	logic [8:0]                 reg_idx;
	logic                       bus_req;

	// feedback ordering: hs drain/source pairs, then ls drains
	genvar g;
	generate
		for (g = 0; g < mcbr_pkg::FB_W; g++) begin : g_fb
			if (g < mcbr_pkg::FB_LS_BASE) begin : g_hs
				if (g % 2 == 0) begin : g_drain
					assign fb_vec[g] = high_drv_drain_fb[g/2];
				end else begin : g_src
					assign fb_vec[g] = high_drv_source_fb[g/2];
				end
			end else begin : g_ls
				assign fb_vec[g] =
					low_drv_drain_fb[g-mcbr_pkg::FB_LS_BASE];
			end
		end
	endgenerate

	assign opcode = instr_word[mcbr_pkg::OPC_HI:mcbr_pkg::OPC_LO];

	always_comb begin
		kind = mcbr_pkg::MCBR_NONE;
		if (opcode == mcbr_pkg::OPC_CTL_REL) begin
			kind = mcbr_pkg::MCBR_CTL_REL;
		end else if (opcode == mcbr_pkg::OPC_FB_REL) begin
			kind = mcbr_pkg::MCBR_FB_REL;
		end else if (opcode == mcbr_pkg::OPC_FB_ABS &&
			instr_word[mcbr_pkg::TAIL_HI:mcbr_pkg::TAIL_LO] ==
			mcbr_pkg::TAIL_FB_ABS) begin
			kind = mcbr_pkg::MCBR_FB_ABS;
		end
	end

	// software picks which control word the microcore tests
	assign ctl_word = state_q.ctl[state_q.wsel];
	assign test_vec = (kind == mcbr_pkg::MCBR_CTL_REL) ? ctl_word : fb_vec;

	mcbr_bit_match u_match (
		.vec   (test_vec),
		.index (instr_word[mcbr_pkg::SEL_HI:mcbr_pkg::SEL_LO]),
		.pol   (instr_word[mcbr_pkg::POL_BIT]),
		.match (cond_match)
	);

	// sign extension keeps wraparound inside code RAM width
	assign rel_target = cur_pc + {{(mcbr_pkg::PC_W-mcbr_pkg::OFS_W){
		instr_word[mcbr_pkg::OFS_HI]}},
		instr_word[mcbr_pkg::OFS_HI:mcbr_pkg::OFS_LO]};
	assign abs_target = instr_word[mcbr_pkg::TGT_BIT] ?
		jump_target_set1 : jump_target_set0;
	assign seq_target = cur_pc + mcbr_pkg::PC_STEP;

	assign reg_idx = adr_i[mcbr_pkg::ADR_W-1:mcbr_pkg::IDX_LO];
	assign bus_req = cyc_i && stb_i && !state_q.ack;

	always_comb begin
		state_d = state_q;
		state_d.valid = 1'b0;
		state_d.taken = 1'b0;
		state_d.decoded = 1'b0;
		state_d.ack = bus_req;

		if (instr_valid) begin
			state_d.valid = 1'b1;
			state_d.pc = seq_target;
			if (kind != mcbr_pkg::MCBR_NONE) begin
				state_d.decoded = 1'b1;
			end
			case (kind)
				mcbr_pkg::MCBR_CTL_REL: begin
					if (cond_match) begin
						state_d.pc = rel_target;
					end
				end
				mcbr_pkg::MCBR_FB_ABS: begin
					if (cond_match) begin
						state_d.pc = abs_target;
					end
				end
				mcbr_pkg::MCBR_FB_REL: begin
					if (cond_match) begin
						state_d.pc = rel_target;
					end
				end
				default: begin
					state_d.pc = seq_target;
				end
			endcase
			if (kind != mcbr_pkg::MCBR_NONE && cond_match) begin
				state_d.taken = 1'b1;
				state_d.taken_cnt = state_q.taken_cnt + mcbr_pkg::CNT_STEP;
			end
		end

		if (bus_req) begin
			state_d.rdata = mcbr_pkg::RD_ZERO;
			case (reg_idx)
				mcbr_pkg::IDX_CTL_A0: begin
					state_d.rdata[15:0] = state_q.ctl[0];
				end
				mcbr_pkg::IDX_CTL_B0: begin
					state_d.rdata[15:0] = state_q.ctl[1];
				end
				mcbr_pkg::IDX_CTL_A1: begin
					state_d.rdata[15:0] = state_q.ctl[2];
				end
				mcbr_pkg::IDX_CTL_B1: begin
					state_d.rdata[15:0] = state_q.ctl[3];
				end
				mcbr_pkg::IDX_WSEL: begin
					state_d.rdata[1:0] = state_q.wsel;
				end
				mcbr_pkg::IDX_STATUS: begin
					state_d.rdata[mcbr_pkg::PC_W-1:0] = state_q.pc;
					state_d.rdata[16] = state_q.taken;
				end
				mcbr_pkg::IDX_TAKEN: begin
					state_d.rdata[15:0] = state_q.taken_cnt;
				end
				default: begin
					state_d.rdata = mcbr_pkg::RD_ZERO;
				end
			endcase
			if (we_i) begin
				// only the two low byte lanes carry control data
				case (reg_idx)
					mcbr_pkg::IDX_CTL_A0, mcbr_pkg::IDX_CTL_B0,
					mcbr_pkg::IDX_CTL_A1, mcbr_pkg::IDX_CTL_B1: begin
						for (int i = 0; i < mcbr_pkg::CTL_N; i++) begin
							if (reg_idx == ctl_index(i)) begin
								if (sel_i[0]) begin
									state_d.ctl[i][7:0] = dat_i[7:0];
								end
								if (sel_i[1]) begin
									state_d.ctl[i][15:8] = dat_i[15:8];
								end
							end
						end
					end
					mcbr_pkg::IDX_WSEL: begin
						if (sel_i[0]) begin
							state_d.wsel = dat_i[1:0];
						end
					end
					default: begin
						state_d.wsel = state_d.wsel;
					end
				endcase
			end
		end
	end

	function automatic logic [8:0] ctl_index(input int n);
		logic [8:0] r;
		r = mcbr_pkg::IDX_CTL_A0;
		case (n)
			1: r = mcbr_pkg::IDX_CTL_B0;
			2: r = mcbr_pkg::IDX_CTL_A1;
			3: r = mcbr_pkg::IDX_CTL_B1;
			default: r = mcbr_pkg::IDX_CTL_A0;
		endcase
		return r;
	endfunction

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int i = 0; i < mcbr_pkg::CTL_N; i++) begin
				state_q.ctl[i] <= mcbr_pkg::CTL_RESET;
			end
			state_q.wsel      <= mcbr_pkg::WSEL_RESET;
			state_q.ack       <= 1'b0;
			state_q.rdata     <= mcbr_pkg::RD_ZERO;
			state_q.pc        <= '0;
			state_q.valid     <= 1'b0;
			state_q.taken     <= 1'b0;
			state_q.decoded   <= 1'b0;
			state_q.taken_cnt <= mcbr_pkg::CNT_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign dat_o                 = state_q.rdata;
	assign ack_o                 = state_q.ack;
	assign micro_program_counter = state_q.pc;
	assign pc_valid              = state_q.valid;
	assign jump_taken            = state_q.taken;
	assign branch_decoded        = state_q.decoded;

endmodule

// ==== bench/mcbr_fb_model.sv ====
// feedback comparators and jump registers seen by the branch decider
// assumes fb_levels is set by the bench in selector-code order
`timescale 1ns/100ps
module mcbr_fb_model #(
	parameter logic [9:0] JUMP0 = 10'h2a5,
	parameter logic [9:0] JUMP1 = 10'h15a
) (
	input  wire logic [15:0] fb_levels,
	output logic      [4:0]  high_drv_drain_fb,
	output logic      [4:0]  high_drv_source_fb,
	output logic      [5:0]  low_drv_drain_fb,
	output logic      [9:0]  jump_target_set0,
	output logic      [9:0]  jump_target_set1
);
	// spread values so a swapped register select shows
	assign jump_target_set0 = JUMP0;
	assign jump_target_set1 = JUMP1;
	for (genvar i = 0; i < 5; i++) begin : g_hs
		assign high_drv_drain_fb[i]  = fb_levels[2*i];
		assign high_drv_source_fb[i] = fb_levels[2*i+1];
	end
	assign low_drv_drain_fb = fb_levels[15:10];
endmodule

// ==== bench/mcbr_branch_monitor.sv ====
// port assertions for the branch decider
// assumes a bind onto mcbr_branch
`timescale 1ns/100ps
module mcbr_branch_monitor (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic        instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [9:0]  cur_pc,
	input wire logic [9:0]  jump_target_set0,
	input wire logic [9:0]  jump_target_set1,
	input wire logic [4:0]  high_drv_drain_fb,
	input wire logic [4:0]  high_drv_source_fb,
	input wire logic [5:0]  low_drv_drain_fb,
	input wire logic [9:0]  micro_program_counter,
	input wire logic        pc_valid,
	input wire logic        jump_taken,
	input wire logic        branch_decoded
);
	logic [15:0] fbv;
	logic        rel, abs, fbk;
	// both relative forms share bits 15..11
	assign rel = instr_word[15:11] == 5'h02;
	assign abs = instr_word[15:10] == 6'h0e && instr_word[3:0] == 4'h4;
	assign fbk = abs || instr_word[15:10] == 6'h05;
	for (genvar i = 0; i < 5; i++) begin : g_fb
		assign fbv[2*i]   = high_drv_drain_fb[i];
		assign fbv[2*i+1] = high_drv_source_fb[i];
	end
	assign fbv[15:10] = low_drv_drain_fb;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_req; cyc_i && stb_i && !ack_o; endsequence
	sequence s_go(c); instr_valid && c ##1 jump_taken; endsequence
	property p_ack; s_req |=> ack_o ##1 !ack_o; endproperty
	property p_ack_src; ack_o |-> $past(cyc_i && stb_i); endproperty
	property p_pcv; instr_valid |=> pc_valid; endproperty
	property p_pcv_src; pc_valid |-> $past(instr_valid); endproperty
	property p_dec; instr_valid |=> branch_decoded == $past(rel || abs);
	endproperty
	property p_fbk; instr_valid && fbk |=>
		jump_taken == $past(fbv[instr_word[9:6]] == instr_word[5]); endproperty
	property p_rel; s_go(rel) |-> micro_program_counter == $past(cur_pc)
		+ {{5{$past(instr_word[4])}}, $past(instr_word[4:0])}; endproperty
	property p_abs; s_go(abs) |-> micro_program_counter ==
		($past(instr_word[4]) ? $past(jump_target_set1)
		: $past(jump_target_set0)); endproperty
	property p_seq; instr_valid ##1 !jump_taken |->
		micro_program_counter == $past(cur_pc) + 10'h001; endproperty
	property p_tk; jump_taken |-> branch_decoded; endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	a_pcv: assert property (p_pcv) else $error("pc_valid missing");
	a_pcv_src: assert property (p_pcv_src) else $error("pc_valid spurious");
	a_dec: assert property (p_dec) else $error("decode wrong");
	a_fbk: assert property (p_fbk) else $error("feedback test wrong");
	a_rel: assert property (p_rel) else $error("relative target wrong");
	a_abs: assert property (p_abs) else $error("absolute target wrong");
	a_seq: assert property (p_seq) else $error("no-jump pc wrong");
	a_tk: assert property (p_tk) else $error("taken on non-branch");
endmodule

// ==== bench/mcbr_branch_test.sv ====
// self-checking bench for the branch decider and its register slave
// assumes one-cycle answers on both the bus and the instruction port
`timescale 1ns/100ps
module mcbr_branch_test;
	localparam logic [9:0] J0 = 10'h2a5;
	localparam logic [9:0] J1 = 10'h15a;
	logic        core_clk, resetn, cyc_i, stb_i, we_i, ack_o;
	logic        instr_valid, pc_valid, jump_taken, branch_decoded;
	logic [10:0] adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [15:0] instr_word, fbv;
	logic [9:0]  cur_pc, micro_program_counter;
	logic [9:0]  jump_target_set0, jump_target_set1;
	logic [4:0]  high_drv_drain_fb, high_drv_source_fb;
	logic [5:0]  low_drv_drain_fb;
	int          bad_count, cmp_count;
	logic [8:0]  idx [4] = '{9'h101, 9'h102, 9'h121, 9'h122};
	logic [15:0] pat [4] = '{16'h8421, 16'h1248, 16'hf00f, 16'h0ff0};
	mcbr_branch u_mcbr_branch (.*);
	mcbr_fb_model #(.JUMP0(J0), .JUMP1(J1)) u_mcbr_fb_model (
		.fb_levels(fbv), .*);
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(logic w, logic [8:0] a, logic [15:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk);
		{cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h3};
		adr_i <= {a, 2'b00};
		dat_i <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
		if (n >= 20) begin
			bad_count++;
			test_done();
		end
	endtask
	function automatic logic [9:0] rel(logic [9:0] p, logic [4:0] o);
		return p + {{5{o[4]}}, o};
	endfunction
	task automatic issue(logic [15:0] w, logic [9:0] p, logic hit,
		logic dec, logic [9:0] tgt);
		@(posedge core_clk);
		{instr_valid, instr_word, cur_pc} <= {1'b1, w, p};
		@(posedge core_clk);
		instr_valid <= 1'b0;
		@(posedge core_clk);
		chk("pc_valid", 1, pc_valid);
		chk("jump_taken", hit, jump_taken);
		chk("branch_decoded", dec, branch_decoded);
		// no-jump pc wraps inside the 10-bit code space
		chk("pc", hit ? tgt : 10'(p + 10'h001), micro_program_counter);
	endtask
	task automatic t_regs();
		for (int w = 0; w < 4; w++) begin
			wb(0, idx[w], 16'h0000, rd);
			chk("ctl reset", 0, rd);
			wb(1, idx[w], pat[w], rd);
			wb(0, idx[w], 16'h0000, rd);
			chk("ctl rw", {16'h0000, pat[w]}, rd);
		end
		wb(1, 9'h140, 16'hbeef, rd);
		wb(0, 9'h140, 16'h0000, rd);
		chk("unmapped", 0, rd);
	endtask
	task automatic t_ctl();
		logic [4:0] o;
		logic [9:0] p;
		for (int w = 0; w < 4; w++) begin
			wb(1, 9'h130, 16'(w), rd);
			for (int k = 0; k < 16; k++) begin
				o = k[0] ? 5'h0f : 5'h10;
				p = k[0] ? 10'h3fa : 10'h005;
				issue({6'h04, k[3:0], k[1], o}, p,
					pat[w][k] == k[1], 1, rel(p, o));
			end
		end
	endtask
	task automatic t_fb();
		logic [4:0]  o;
		logic [9:0]  p;
		logic [15:0] v;
		for (int f = 0; f < 2; f++) begin
			v = f ? 16'h5a3c : 16'ha5c3;
			fbv <= v;
			for (int k = 0; k < 16; k++) begin
				o = k[0] ? 5'h0f : 5'h10;
				p = k[0] ? 10'h3fa : 10'h005;
				issue({6'h0e, k[3:0], k[1], k[2], 4'h4}, p,
					v[k] == k[1], 1, k[2] ? J1 : J0);
				issue({6'h05, k[3:0], k[1], o}, p,
					v[k] == k[1], 1, rel(p, o));
			end
		end
	endtask
	task automatic t_stat();
		logic [31:0] c0;
		wb(0, 9'h130, 16'h0000, rd);
		chk("wsel", 3, rd);
		wb(0, 9'h132, 16'h0000, c0);
		issue({6'h05, 4'h0, fbv[0], 5'h01}, 10'h100, 1, 1, 10'h101);
		wb(0, 9'h131, 16'h0000, rd);
		chk("status pc", 32'h0000_0101, rd);
		wb(0, 9'h132, 16'h0000, rd);
		chk("taken count", c0 + 32'h0000_0001, rd);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		{resetn, cyc_i, stb_i, we_i, instr_valid} = 5'h00;
		{adr_i, sel_i, dat_i, instr_word, cur_pc, fbv} = '0;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		t_regs();
		t_ctl();
		t_fb();
		t_stat();
		issue(16'h3815, 10'h3ff, 0, 0, 10'h000);
		issue(16'h0000, 10'h123, 0, 0, 10'h000);
		test_done();
	end
endmodule
bind mcbr_branch mcbr_branch_monitor u_mcbr_branch_monitor (.*);
